/* tmr8_pkg.sv */
/*
 package of the 8-bit timer counter/compare core: register offsets, field positions, reset values
 and mode codes.
 assumes an APB master with 32-bit data; all offsets are byte addresses.
*/
package tmr8_pkg;

   // ********************************
   // register map
   // ********************************
   localparam logic [7:0] OFS_CTRL_A   = 8'h00;
   localparam logic [7:0] OFS_CTRL_B   = 8'h04;
   localparam logic [7:0] OFS_COUNT    = 8'h08;
   localparam logic [7:0] OFS_CMP_A    = 8'h0C;
   localparam logic [7:0] OFS_CMP_B    = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_IRQ_FLAG = 8'h18;
   localparam logic [7:0] OFS_PORT     = 8'h1C;

   // ********************************
   // field positions
   // ********************************
   // control a: [1:0] mode bits 1..0, [5:4] action b, [7:6] action a
   localparam int CA_WGM_LO  = 0;
   localparam int CA_ACT_B   = 4;
   localparam int CA_ACT_A   = 6;
   // control b: [2:0] tick select, [3] mode bit 2, [6] force b, [7] force a
   localparam int CB_CS      = 0;
   localparam int CB_WGM_HI  = 3;
   localparam int CB_FORCE_B = 6;
   localparam int CB_FORCE_A = 7;
   // flags/mask: [0] overflow, [1] compare a, [2] compare b
   localparam int FL_OVF     = 0;
   localparam int FL_CMPA    = 1;
   localparam int FL_CMPB    = 2;
   // port register: [0] out value a, [1] out value b, [2] dir a, [3] dir b
   localparam int PT_VAL_A   = 0;
   localparam int PT_VAL_B   = 1;
   localparam int PT_DIR_A   = 2;
   localparam int PT_DIR_B   = 3;

   localparam logic [7:0]  BYTE_ZERO = 8'h00;
   localparam logic [7:0]  BOTTOM    = 8'h00;
   localparam logic [7:0]  MAX       = 8'hFF;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [2:0]  CS_STOP   = 3'h0;

   // ********************************
   // waveform modes and output actions
   // ********************************
   localparam logic [2:0] WGM_NORMAL  = 3'h0;
   localparam logic [2:0] WGM_PC_FF   = 3'h1;
   localparam logic [2:0] WGM_CTC     = 3'h2;
   localparam logic [2:0] WGM_FAST_FF = 3'h3;
   localparam logic [2:0] WGM_PC_CMP  = 3'h5;
   localparam logic [2:0] WGM_FAST_CA = 3'h7;

   localparam logic [1:0] ACT_NONE    = 2'h0;
   localparam logic [1:0] ACT_TOGGLE  = 2'h1;
   localparam logic [1:0] ACT_CLEAR   = 2'h2;
   localparam logic [1:0] ACT_SET     = 2'h3;

   typedef enum logic [1:0] {TMR8_IDLE, TMR8_ACCESS} tmr8_apb_t;

endpackage

/* tmr8_cmp_ch.sv */
/*
 one output compare channel: double buffered compare value, match flag, waveform output register.
 assumes tick, count-write and mode information come from the counter core on the same clock.
*/
`timescale 1ns/1ns
module tmr8_cmp_ch
   import tmr8_pkg::*;
(
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // cpu side
   input  wire logic       cmp_wr,
   input  wire logic [7:0] cmp_wdata,
   input  wire logic [1:0] compare_output_action,
   input  wire logic       force_strobe,
   input  wire logic       flag_clr,
   // counter side
   input  wire logic       timer_tick,
   input  wire logic [7:0] timer_count,
   input  wire logic       pwm_mode,
   input  wire logic       fast_pwm,
   input  wire logic       load_point,
   input  wire logic       at_bottom,
   input  wire logic       match_block,
   // results
   output logic [7:0]      compare_value,
   output logic [7:0]      compare_buffer,
   output logic            match,
   output logic            compare_flag,
   output logic            waveform_output
);
   import tmr8_pkg::*;

   logic [7:0] value_ff;
   logic [7:0] buf_ff;
   logic       flag_ff;
   logic       wave_ff;
   logic       nxt_wave;
   logic       hit;

   assign compare_value  = value_ff;
   assign compare_buffer = buf_ff;
   assign compare_flag   = flag_ff;
   assign waveform_output = wave_ff;
   assign match          = (timer_count == value_ff);

   // ********************************
   // compare value and buffer
   // ********************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         value_ff <= BYTE_ZERO;
         buf_ff   <= BYTE_ZERO;
      end
      else
      begin
         if (cmp_wr)
            buf_ff <= cmp_wdata;
         if (!pwm_mode && cmp_wr)
            value_ff <= cmp_wdata;
         else if (!pwm_mode)
            value_ff <= buf_ff;
         else if (timer_tick && load_point)
            value_ff <= buf_ff;
      end
   end

   // ********************************
   // match flag: set by the tick that sees the match
   // ********************************
   // set wins over a simultaneous clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_ff <= 1'b0;
      else if (hit)
         flag_ff <= 1'b1;
      else if (flag_clr)
         flag_ff <= 1'b0;
   end

   assign hit = timer_tick && match && !match_block;

   // ********************************
   // waveform output register
   // ********************************
   always_comb
   begin
      nxt_wave = wave_ff;
      if (force_strobe && !pwm_mode)
      begin
         case (compare_output_action)
            ACT_TOGGLE: nxt_wave = !wave_ff;
            ACT_CLEAR:  nxt_wave = 1'b0;
            ACT_SET:    nxt_wave = 1'b1;
            default:    nxt_wave = wave_ff;
         endcase
      end
      else if (hit)
      begin
         case (compare_output_action)
            ACT_TOGGLE: nxt_wave = !wave_ff;
            ACT_CLEAR:  nxt_wave = pwm_mode ? 1'b0 : 1'b0;
            ACT_SET:    nxt_wave = 1'b1;
            default:    nxt_wave = wave_ff;
         endcase
      end
      else if (timer_tick && fast_pwm && at_bottom)
      begin
         // fast pwm: opposite level at bottom
         case (compare_output_action)
            ACT_CLEAR: nxt_wave = 1'b1;
            ACT_SET:   nxt_wave = 1'b0;
            default:   nxt_wave = wave_ff;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wave_ff <= 1'b0;
      else
         wave_ff <= nxt_wave;
   end

endmodule // tmr8_cmp_ch

/* tmr8_core.sv */
/*
 top of the 8-bit timer counter/compare core: apb register file, counter unit, two compare channels
 and the pin override.
 assumes a prescaler outside delivers a single-cycle tick enable on pclk; pins are driven by the
 port pad logic using the outputs here.
*/
// How it works
// - tick select zero stops the counter
// - each tick clears, increments or decrements counter
// - cpu reads and writes count any time
// - cpu count write beats clear or count
// - mode: two bits control a, one control b
// - overflow flag set per mode, may interrupt
// - comparators match count against both values
// - match sets compare flag one tick later
// - enabled flag interrupts, cleared on service
// - writing one clears a compare flag
// - compare values buffered only in pwm modes
// - buffered value loads at top in every pwm mode
// - cpu reaches buffer or active value
// - force strobe acts like match in non-pwm modes only, no flag
// - count write blocks matches next tick
// - waveform registers survive mode change
// - action bits take effect next match
// - reset clears waveform output registers
// - nonzero action overrides port output value
// - pin shows wave only when output
// - action zero leaves waveform register alone
// - bottom 0x00, max 0xFF, top per mode
// - mode 0 wraps, overflow at zero
// - mode 2 clears on channel a match
// - modes 3 and 7 single-slope to top
`timescale 1ns/1ns
module tmr8_core
   import tmr8_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // tick sources, one per nonzero select code
   input  wire logic [7:1]  tick_sources,
   // interrupt service acknowledges
   input  wire logic        ack_overflow,
   input  wire logic        ack_compare_a,
   input  wire logic        ack_compare_b,
   // interrupt requests
   output logic             irq_overflow,
   output logic             irq_compare_a,
   output logic             irq_compare_b,
   // pins
   output logic             pin_a_out,
   output logic             pin_a_oe_n,
   output logic             pin_b_out,
   output logic             pin_b_oe_n
);
   import tmr8_pkg::*;

   // ********************************
   // registers and wires
   // ********************************
   logic [7:0]  ctrl_a_ff;
   logic [7:0]  ctrl_b_ff;
   logic [2:0]  mask_ff;
   logic [3:0]  port_ff;
   logic [7:0]  timer_count_ff;
   logic        ovf_ff;
   logic        blk_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic [2:0]  irq_ff;
   logic [3:0]  pin_ff;
   tmr8_apb_t   apb_state_ff;
   logic [7:0]  nxt_count;
   logic [31:0] nxt_rdata;
   logic        nxt_err;
   logic [2:0]  waveform_mode_field;
   logic [2:0]  tick_source_select;
   logic        timer_tick;
   logic        wr_en;
   logic        rd_en;
   logic        wr_count;
   logic        pwm_mode;
   logic        fast_pwm;
   logic [7:0]  top_value;
   logic        at_top;
   logic        at_bottom;
   logic        load_point;
   logic        match_a;
   logic        match_b;
   logic [7:0]  value_a;
   logic [7:0]  value_b;
   logic [7:0]  buffer_a;
   logic [7:0]  buffer_b;
   logic        compare_flag_a;
   logic        compare_flag_b;
   logic        waveform_output_a;
   logic        waveform_output_b;
   logic        clr_a;
   logic        clr_b;
   logic        dir_down_ff;

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq_overflow  = irq_ff[FL_OVF];
   assign irq_compare_a = irq_ff[FL_CMPA];
   assign irq_compare_b = irq_ff[FL_CMPB];
   assign pin_a_out  = pin_ff[0];
   assign pin_a_oe_n = pin_ff[1];
   assign pin_b_out  = pin_ff[2];
   assign pin_b_oe_n = pin_ff[3];

   // ********************************
   // decode of mode and tick
   // ********************************
   assign waveform_mode_field = {ctrl_b_ff[CB_WGM_HI], ctrl_a_ff[CA_WGM_LO +: 2]};
   assign tick_source_select  = ctrl_b_ff[CB_CS +: 3];
   assign timer_tick = (tick_source_select != CS_STOP) && tick_sources[tick_source_select];
   assign pwm_mode   = (waveform_mode_field != WGM_NORMAL) && (waveform_mode_field != WGM_CTC);
   assign fast_pwm   = (waveform_mode_field == WGM_FAST_FF) || (waveform_mode_field == WGM_FAST_CA);
   assign top_value  = (waveform_mode_field == WGM_FAST_CA || waveform_mode_field == WGM_PC_CMP
                        || waveform_mode_field == WGM_CTC) ? value_a : MAX;
   assign at_top     = (timer_count_ff == top_value);
   assign at_bottom  = (timer_count_ff == BOTTOM);
   // fast pwm reloads at top, dual slope at top (turn point)
   assign load_point = at_top;

   // ********************************
   // apb access
   // ********************************
   // one wait-free access phase; answer registered at the access edge
   assign wr_en    = psel && penable && pwrite && pready_ff;
   assign rd_en    = psel && penable && !pwrite && pready_ff;
   assign wr_count = wr_en && (paddr == OFS_COUNT);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         apb_state_ff <= TMR8_IDLE;
      else
      begin
         case (apb_state_ff)
            TMR8_IDLE:   apb_state_ff <= (psel && !penable) ? TMR8_ACCESS : TMR8_IDLE;
            TMR8_ACCESS: apb_state_ff <= TMR8_IDLE;
            default:     apb_state_ff <= TMR8_IDLE;
         endcase
      end
   end

   always_comb
   begin
      nxt_err   = 1'b0;
      nxt_rdata = WORD_ZERO;
      case (paddr)
         OFS_CTRL_A:   nxt_rdata = {24'h00_0000, ctrl_a_ff};
         OFS_CTRL_B:   nxt_rdata = {24'h00_0000, 2'b00, ctrl_b_ff[5:0]};
         OFS_COUNT:    nxt_rdata = {24'h00_0000, timer_count_ff};
         OFS_CMP_A:    nxt_rdata = {24'h00_0000, pwm_mode ? buffer_a : value_a};
         OFS_CMP_B:    nxt_rdata = {24'h00_0000, pwm_mode ? buffer_b : value_b};
         OFS_IRQ_MASK: nxt_rdata = {29'h0000_0000, mask_ff};
         OFS_IRQ_FLAG: nxt_rdata = {29'h0000_0000, compare_flag_b, compare_flag_a, ovf_ff};
         OFS_PORT:     nxt_rdata = {28'h000_0000, port_ff};
         default:      nxt_err = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff  <= 1'b0;
         prdata_ff  <= WORD_ZERO;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff  <= psel && !penable && (apb_state_ff == TMR8_IDLE);
         pslverr_ff <= psel && !penable && nxt_err;
         // write setups park read data at zero, so refused writes never show stale data
         if (psel && !penable)
            prdata_ff <= pwrite ? WORD_ZERO : nxt_rdata;
      end
   end

   // ********************************
   // control registers
   // ********************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_a_ff <= BYTE_ZERO;
         ctrl_b_ff <= BYTE_ZERO;
         mask_ff   <= 3'b000;
         port_ff   <= 4'h0;
      end
      else
      begin
         // force bits are strobes, held for one cycle only
         ctrl_b_ff[CB_FORCE_A] <= 1'b0;
         ctrl_b_ff[CB_FORCE_B] <= 1'b0;
         if (wr_en && paddr == OFS_CTRL_A)
            ctrl_a_ff <= pwdata[7:0];
         if (wr_en && paddr == OFS_CTRL_B)
            ctrl_b_ff <= pwdata[7:0];
         if (wr_en && paddr == OFS_IRQ_MASK)
            mask_ff <= pwdata[2:0];
         if (wr_en && paddr == OFS_PORT)
            port_ff <= pwdata[3:0];
      end
   end

   // ********************************
   // counter unit
   // ********************************
   always_comb
   begin
      nxt_count = timer_count_ff;
      if (wr_count)
         nxt_count = pwdata[7:0];
      else if (timer_tick)
      begin
         case (waveform_mode_field)
            WGM_NORMAL:               nxt_count = timer_count_ff + 8'h01;
            WGM_CTC:                  nxt_count = match_a ? BOTTOM : timer_count_ff + 8'h01;
            WGM_FAST_FF, WGM_FAST_CA: nxt_count = at_top ? BOTTOM : timer_count_ff + 8'h01;
            WGM_PC_FF, WGM_PC_CMP:    nxt_count = dir_down_ff ? timer_count_ff - 8'h01
                                                              : timer_count_ff + 8'h01;
            default:                  nxt_count = timer_count_ff + 8'h01;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timer_count_ff <= BYTE_ZERO;
      else
         timer_count_ff <= nxt_count;
   end

   // dual-slope direction; turns down on the tick at top, so count passes top by one; turns up at 0x01, a minimal turn at bottom
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dir_down_ff <= 1'b0;
      else if (timer_tick && !wr_count)
      begin
         if (at_top && !dir_down_ff)
            dir_down_ff <= 1'b1;
         else if (timer_count_ff == 8'h01 && dir_down_ff)
            dir_down_ff <= 1'b0;
      end
   end

   // count write blocks matches until the next tick has passed, even when stopped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         blk_ff <= 1'b0;
      else if (wr_count)
         blk_ff <= 1'b1;
      else if (timer_tick)
         blk_ff <= 1'b0;
   end

   // ********************************
   // overflow flag
   // ********************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ovf_ff <= 1'b0;
      else if (timer_tick && !wr_count && (nxt_count == BOTTOM) && (timer_count_ff == MAX
               || (fast_pwm && at_top) || (pwm_mode && !fast_pwm && timer_count_ff == 8'h01)))
         ovf_ff <= 1'b1;
      else if (ack_overflow || (wr_en && paddr == OFS_IRQ_FLAG && pwdata[FL_OVF]))
         ovf_ff <= 1'b0;
   end

   // ********************************
   // compare channels
   // ********************************
   assign clr_a = ack_compare_a || (wr_en && paddr == OFS_IRQ_FLAG && pwdata[FL_CMPA]);
   assign clr_b = ack_compare_b || (wr_en && paddr == OFS_IRQ_FLAG && pwdata[FL_CMPB]);

   tmr8_cmp_ch u_ch_a
   (
      .pclk                  (pclk),
      .presetn               (presetn),
      .cmp_wr                (wr_en && paddr == OFS_CMP_A),
      .cmp_wdata             (pwdata[7:0]),
      .compare_output_action (ctrl_a_ff[CA_ACT_A +: 2]),
      .force_strobe          (ctrl_b_ff[CB_FORCE_A]),
      .flag_clr              (clr_a),
      .timer_tick            (timer_tick),
      .timer_count           (timer_count_ff),
      .pwm_mode              (pwm_mode),
      .fast_pwm              (fast_pwm),
      .load_point            (load_point),
      .at_bottom             (at_top),
      .match_block           (blk_ff || wr_count),
      .compare_value         (value_a),
      .compare_buffer        (buffer_a),
      .match                 (match_a),
      .compare_flag          (compare_flag_a),
      .waveform_output       (waveform_output_a)
   );

   tmr8_cmp_ch u_ch_b
   (
      .pclk                  (pclk),
      .presetn               (presetn),
      .cmp_wr                (wr_en && paddr == OFS_CMP_B),
      .cmp_wdata             (pwdata[7:0]),
      .compare_output_action (ctrl_a_ff[CA_ACT_B +: 2]),
      .force_strobe          (ctrl_b_ff[CB_FORCE_B]),
      .flag_clr              (clr_b),
      .timer_tick            (timer_tick),
      .timer_count           (timer_count_ff),
      .pwm_mode              (pwm_mode),
      .fast_pwm              (fast_pwm),
      .load_point            (load_point),
      .at_bottom             (at_top),
      .match_block           (blk_ff || wr_count),
      .compare_value         (value_b),
      .compare_buffer        (buffer_b),
      .match                 (match_b),
      .compare_flag          (compare_flag_b),
      .waveform_output       (waveform_output_b)
   );

   // ********************************
   // interrupts and pins
   // ********************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_ff <= 3'b000;
         pin_ff <= 4'b1010;
      end
      else
      begin
         irq_ff <= mask_ff & {compare_flag_b, compare_flag_a, ovf_ff};
         // nonzero action selects the wave; direction bit alone gates the pin
         pin_ff[0] <= (ctrl_a_ff[CA_ACT_A +: 2] != ACT_NONE) ? waveform_output_a : port_ff[PT_VAL_A];
         pin_ff[1] <= !port_ff[PT_DIR_A];
         pin_ff[2] <= (ctrl_a_ff[CA_ACT_B +: 2] != ACT_NONE) ? waveform_output_b : port_ff[PT_VAL_B];
         pin_ff[3] <= !port_ff[PT_DIR_B];
      end
   end

endmodule // tmr8_core

/* tmr8_core_properties.sv */
/*
 port checker for the timer counter/compare core: bus handshake, refusals, reset pins, flag clearing.
 assumes it is bound to tmr8_core and that everything runs on pclk.
*/
`timescale 1ns/1ns
module tmr8_core_properties
   import tmr8_pkg::*;
(
   // clock, reset and bus
   input wire logic        pclk, presetn, psel, penable, pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic        pready, pslverr,
   // ticks, service, interrupt, pins
   input wire logic [7:1]  tick_sources,
   input wire logic        ack_compare_a, irq_compare_a,
   input wire logic        pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ****************************************
   // properties
   // ****************************************
   property p_ready_after_setup;
      psel && !penable |=> pready && psel && penable;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
   property p_ready_has_setup;
      pready |-> $past(psel && !penable);
   endproperty
   a_ready_has_setup: assert property (p_ready_has_setup) else $error("ready without setup");
   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
   property p_unmapped;
      psel && !penable && paddr > OFS_PORT |=> pslverr && prdata == WORD_ZERO;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_mapped;
      psel && !penable && paddr <= OFS_PORT && paddr[1:0] == 2'h0 |=> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   property p_reset_pins;
      $rose(presetn) |-> !pin_a_out && !pin_b_out && pin_a_oe_n && pin_b_oe_n;
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("pins not at reset level");
   // no tick in the clearing cycle, so a pending set cannot win over the clear
   property p_ack_clears_a;
      ack_compare_a && tick_sources == 7'h00 |-> ##2 !irq_compare_a;
   endproperty
   a_ack_clears_a: assert property (p_ack_clears_a) else $error("service left compare a request");
   property p_w1c_a;
      psel && penable && pready && pwrite && paddr == OFS_IRQ_FLAG && pwdata[FL_CMPA]
         && tick_sources == 7'h00 |-> ##2 !irq_compare_a;
   endproperty
   a_w1c_a: assert property (p_w1c_a) else $error("write one left compare a request");
endmodule // tmr8_core_properties

bind tmr8_core tmr8_core_properties tmr8_core_properties_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tick_sources(tick_sources), .ack_compare_a(ack_compare_a),
   .irq_compare_a(irq_compare_a), .pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n),
   .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n));

/* tmr8_core_tb.sv */
/*
 self-checking bench of the timer counter/compare core, driven over apb with single ticks.
 assumes zero wait-state slave; only select code 1 is used as tick source.
*/
`timescale 1ns/1ns
module tmr8_core_tb;
   import tmr8_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
   logic        pready, pslverr, rerr;
   logic [7:1]  tick_sources = 7'h00;
   logic        ack_overflow = 1'b0, ack_compare_a = 1'b0, ack_compare_b = 1'b0;
   logic        irq_overflow, irq_compare_a, irq_compare_b, pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n;
   int          miscompares = 0, check_count = 0, cycles = 0;

   always #50 pclk = ~pclk;

   tmr8_core tmr8_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tick_sources(tick_sources), .ack_overflow(ack_overflow),
      .ack_compare_a(ack_compare_a), .ack_compare_b(ack_compare_b), .irq_overflow(irq_overflow),
      .irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b), .pin_a_out(pin_a_out),
      .pin_a_oe_n(pin_a_oe_n), .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n));

   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // request held until ready is sampled high; idle cycle after so psel is never reassigned at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h00_0000, d});
   endtask

   task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(name, {24'h00_0000, exp}, rdat);
   endtask

   task automatic tick(input int n);
      repeat (n)
      begin
         tick_sources <= 7'h01;
         @(posedge pclk);
         tick_sources <= 7'h00;
         @(posedge pclk);
      end
   endtask

   task automatic print_verdict();
      if (miscompares == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ****************************************
   // timeout and main sequence
   // ****************************************
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         print_verdict();
      end
   end

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd("count", OFS_COUNT, 8'h00);
      rd("flags", OFS_IRQ_FLAG, 8'h00);
      apb(1'b0, 8'h20, 32'h0000_0000);
      check("unmapped error", 32'h0000_0001, {31'h0000_0000, rerr});
      wr(OFS_COUNT, 8'h10);
      tick(3);
      rd("stopped count", OFS_COUNT, 8'h10);
      wr(OFS_CTRL_B, 8'h01);
      wr(OFS_COUNT, 8'hFE);
      tick(1);
      rd("count up", OFS_COUNT, 8'hFF);
      tick(1);
      rd("wrapped count", OFS_COUNT, 8'h00);
      rd("overflow flag", OFS_IRQ_FLAG, 8'h01);
      wr(OFS_IRQ_MASK, 8'h03);
      @(posedge pclk);
      check("overflow irq", 32'h0000_0001, {31'h0000_0000, irq_overflow});
      ack_overflow <= 1'b1;
      @(posedge pclk);
      ack_overflow <= 1'b0;
      rd("serviced flags", OFS_IRQ_FLAG, 8'h00);
      wr(OFS_CMP_A, 8'h05);
      wr(OFS_CMP_B, 8'h40);
      wr(OFS_COUNT, 8'h03);
      tick(2);
      rd("flag at match", OFS_IRQ_FLAG, 8'h00);
      tick(1);
      rd("flag after match", OFS_IRQ_FLAG, 8'h02);
      check("compare irq", 32'h0000_0001, {31'h0000_0000, irq_compare_a});
      wr(OFS_IRQ_FLAG, 8'h02);
      rd("cleared flags", OFS_IRQ_FLAG, 8'h00);
      wr(OFS_CMP_B, 8'h07);
      wr(OFS_COUNT, 8'h07);
      tick(2);
      rd("blocked match", OFS_IRQ_FLAG, 8'h00);
      wr(OFS_CMP_B, 8'h09);
      tick(1);
      rd("match b flags", OFS_IRQ_FLAG, 8'h04);
      check("masked irq b", 32'h0000_0000, {31'h0000_0000, irq_compare_b});
      ack_compare_b <= 1'b1;
      @(posedge pclk);
      ack_compare_b <= 1'b0;
      rd("serviced b", OFS_IRQ_FLAG, 8'h00);
      wr(OFS_CTRL_A, 8'h02);
      rd("mode bits", OFS_CTRL_A, 8'h02);
      wr(OFS_CMP_A, 8'h03);
      wr(OFS_COUNT, 8'h00);
      tick(4);
      rd("match clear", OFS_COUNT, 8'h00);
      rd("top flag", OFS_IRQ_FLAG, 8'h02);
      wr(OFS_IRQ_FLAG, 8'h07);
      // stopped timer, so only the force strobe can move the waveform register
      wr(OFS_PORT, 8'h04);
      wr(OFS_CTRL_A, 8'h52);
      wr(OFS_CTRL_B, 8'hC0);
      repeat (2) @(posedge pclk);
      check("pin a", 32'h0000_0001, {31'h0000_0000, pin_a_out});
      check("pin b", 32'h0000_0001, {31'h0000_0000, pin_b_out});
      check("pin a enable", 32'h0000_0000, {31'h0000_0000, pin_a_oe_n});
      check("pin b enable", 32'h0000_0001, {31'h0000_0000, pin_b_oe_n});
      rd("forced flags", OFS_IRQ_FLAG, 8'h00);
      rd("forced count", OFS_COUNT, 8'h00);
      wr(OFS_CTRL_A, 8'h53);
      repeat (2) @(posedge pclk);
      check("pin a kept", 32'h0000_0001, {31'h0000_0000, pin_a_out});
      wr(OFS_CTRL_A, 8'h03);
      repeat (2) @(posedge pclk);
      check("port value", 32'h0000_0000, {31'h0000_0000, pin_a_out});
      check("port value b", 32'h0000_0000, {31'h0000_0000, pin_b_out});
      print_verdict();
   end
endmodule // tmr8_core_tb
